// file: rtl/cnbc_cpu_end.sv
// Purpose: Processor end of the non-pipelined host bus, with write data FIFO
// Assumes: Bus inputs synchronous to clk; system keeps next_address_n negated
// Notes:   One cycle outstanding; reads and fills, single and burst writes
`timescale 1ns/100ps
`default_nettype none
module cnbc_fifo #(
  parameter int W = 64,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];

  always_comb begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
endmodule

// Notes on behaviour
// - Only one bus cycle outstanding at once
// - Single read drives address in first clock
// - Sample ready from second clock; waits otherwise
// - Read parity error flagged two clocks later
// - Cache enable at first ready makes burst
// - System keeps next address negated throughout
// - Shared write hit upgrades on policy high
// - Line fill: four beats, cacheable held
// - System gives exactly four ready strobes
// - Policy with page attribute picks fill state
// - Only first burst address driven; system predicts
// - Burst beat parity error two clocks later
// - Two burst orders; split order after reset
// - Split: single read first, cacheable negated
// - Split order from aligned half-line start
// - Split order: policy sampled in the single read, not in the burst
// - Linear order wraps from first word
// - Burst write: four beats, no sampling
// - Write data from second clock, next after ready
// - Burst write starts line aligned, ascending
// - Idle clock after every burst write
// - Backoff or reset returns bus idle
module cnbc_cpu_end (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Request
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic                        req_line,
  input  wire logic                        req_io,
  input  wire logic                        req_page_wt,
  input  wire logic                        req_shared_hit,
  input  wire logic [cnbc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [cnbc_pkg::LANES-1:0]  req_byte_en,
  // Write data
  input  wire logic                        wdata_valid,
  output logic                             wdata_ready,
  input  wire logic [cnbc_pkg::DATA_W-1:0] wdata,
  // Read data and status
  output logic                             rdata_valid,
  output logic [cnbc_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rdata_word,
  output logic                             cycle_done,
  output logic                             fill_valid,
  output logic [1:0]                       fill_state,
  output logic                             to_exclusive,
  // Configuration
  input  wire logic                        linear_burst,
  input  wire logic                        write_through_cfg,
  // Host bus
  cnbc_bus_if.cpu                          bus
);
  import cnbc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_T1, ST_T2, ST_GAP, ST_HOLD} cnbc_state_t;

  cnbc_state_t              st_q, st_d;
  logic                     wr_q, wr_d, line_q, line_d, split_q, split_d, burst_q, burst_d;
  logic                     io_q, io_d, pwt_q, pwt_d, shr_q, shr_d, wps_q, wps_d;
  logic [1:0]               first_q, first_d, beat_q, beat_d;
  logic [2:0]               nload_q, nload_d;
  logic [ADDR_W-1:LINE_LSB] base_q, base_d;
  logic [LANES-1:0]         be_q, be_d;
  logic [DATA_W-1:0]        buf_q [BEATS];
  logic                     rdy_q, rdy_d, done_q, done_d, fv_q, fv_d, ex_q, ex_d;
  logic                     rdv_q, rdv_d, perr1_q, perr1_d, perr_n_q, perr_n_d;
  logic [1:0]               fs_q, fs_d, rw_q, rw_d;
  logic [DATA_W-1:0]        rd_q, rd_d, dout_q, dout_d;
  logic                     ads_n_q, ads_n_d, cache_n_q, cache_n_d, oe_q, oe_d;
  logic                     strobe, last, accept, pop, fifo_v, fifo_rdy;
  logic [DATA_W-1:0]        fifo_d;
  logic [2:0]               need;

  cnbc_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_wfifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (wdata_valid),
    .in_ready  (fifo_rdy),
    .in_data   (wdata),
    .out_valid (fifo_v),
    .out_ready (pop),
    .out_data  (fifo_d)
  );

  assign wdata_ready = fifo_rdy;

  assign need   = line_q ? 3'(BEATS) : 3'h1;
  assign pop    = (st_q == ST_LOAD) && fifo_v && (nload_q != need);
  assign accept = (st_q == ST_IDLE) && rdy_q && req_valid;
  // Ready counts from T2 on; backoff wins
  assign strobe = (st_q == ST_T2) && !bus.transfer_ready_n && bus.backoff_n;

  always_comb begin
    st_d = st_q;  wr_d = wr_q;  line_d = line_q;  split_d = split_q;  burst_d = burst_q;
    io_d = io_q;  pwt_d = pwt_q;  shr_d = shr_q;  wps_d = wps_q;
    first_d = first_q;  beat_d = beat_q;  nload_d = nload_q;  base_d = base_q;  be_d = be_q;
    done_d = 1'b0;  fv_d = 1'b0;  ex_d = 1'b0;  rdv_d = 1'b0;  fs_d = fs_q;
    rw_d = rw_q;  rd_d = rd_q;  perr1_d = 1'b0;
    last = 1'b0;
    if (pop) begin
      nload_d = nload_q + 3'h1;
    end
    case (st_q)
      ST_IDLE: begin
        if (accept) begin
          wr_d    = req_write;
          line_d  = req_line;
          io_d    = req_io;
          pwt_d   = req_page_wt;
          shr_d   = req_shared_hit;
          be_d    = req_line ? '1 : req_byte_en;
          base_d  = req_addr[ADDR_W-1:LINE_LSB];
          beat_d  = 2'h0;
          nload_d = 3'h0;
          wps_d   = 1'b0;
          // Line writes always start on the line boundary
          first_d = (req_write && req_line) ? ALIGNED_WORD : req_addr[LINE_LSB-1:WORD_LSB];
          // Split order fetches the odd word alone before the burst
          split_d = req_line && !req_write && !linear_burst && req_addr[WORD_LSB];
          burst_d = req_line && req_write;
          st_d    = req_write ? ST_LOAD : ST_T1;
        end
      end
      ST_LOAD: begin
        if (nload_q == need) begin
          st_d = ST_T1;
        end
      end
      ST_T1: begin
        st_d = ST_T2;
      end
      ST_T2: begin
        if (strobe) begin
          if (!wr_q) begin
            rdv_d   = 1'b1;
            rd_d    = bus.data;
            rw_d    = cnbc_burst_word(first_q, beat_q);
            perr1_d = |((cnbc_lane_par(bus.data) ^ bus.parity) & be_q);
          end
          if (beat_q == 2'h0 && !wr_q) begin
            if (split_q) begin
              wps_d = bus.write_policy_sel;
            end else if (line_q && !burst_q) begin
              burst_d = !bus.cache_enable_n;
              wps_d   = bus.write_policy_sel;
            end
          end
          if (beat_q == 2'h0 && wr_q && !line_q && shr_q && bus.write_policy_sel) begin
            ex_d = 1'b1;
          end
          last = !burst_d || (beat_q == LAST_BEAT);
          if (split_q) begin
            if (!bus.cache_enable_n) begin
              // Burst follows from the half-line start, cacheable now driven
              split_d = 1'b0;
              burst_d = 1'b1;
              first_d = {first_q[1], 1'b0};
              st_d    = ST_T1;
            end else begin
              done_d = 1'b1;
              st_d   = ST_IDLE;
            end
          end else if (last) begin
            done_d = 1'b1;
            fv_d   = line_q && !wr_q && burst_d;
            fs_d   = (wps_d && !pwt_q && !write_through_cfg) ? FILL_EXCL : FILL_SHARED;
            st_d   = (wr_q && burst_q) ? ST_GAP : ST_IDLE;
          end else begin
            beat_d = beat_q + 2'h1;
          end
        end
      end
      ST_GAP: begin
        st_d = ST_IDLE;
      end
      ST_HOLD: begin
        if (bus.backoff_n) begin
          beat_d = 2'h0;
          st_d   = ST_T1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Aborted cycle restarts whole
    if (!bus.backoff_n && (st_d == ST_T1 || st_d == ST_T2)) begin
      st_d    = ST_HOLD;
      beat_d  = 2'h0;
      done_d  = 1'b0;
      fv_d    = 1'b0;
      ex_d    = 1'b0;
    end
    rdy_d     = (st_d == ST_IDLE);
    ads_n_d   = (st_d != ST_T1);
    cache_n_d = !(line_d && !split_d && (st_d == ST_T1 || st_d == ST_T2));
    oe_d      = wr_d && (st_d == ST_T2);
    dout_d    = buf_q[beat_d];
    perr_n_d  = !perr1_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;  wr_q <= 1'b0;  line_q <= 1'b0;  split_q <= 1'b0;  burst_q <= 1'b0;
      io_q <= 1'b0;  pwt_q <= 1'b0;  shr_q <= 1'b0;  wps_q <= 1'b0;
      first_q <= 2'h0;  beat_q <= 2'h0;  nload_q <= 3'h0;  base_q <= '0;  be_q <= '0;
      rdy_q <= 1'b0;  done_q <= 1'b0;  fv_q <= 1'b0;  ex_q <= 1'b0;  rdv_q <= 1'b0;
      perr1_q <= 1'b0;  perr_n_q <= 1'b1;  fs_q <= FILL_NONE;  rw_q <= 2'h0;
      rd_q <= '0;  dout_q <= '0;  ads_n_q <= 1'b1;  cache_n_q <= 1'b1;  oe_q <= 1'b0;
    end else begin
      st_q <= st_d;  wr_q <= wr_d;  line_q <= line_d;  split_q <= split_d;  burst_q <= burst_d;
      io_q <= io_d;  pwt_q <= pwt_d;  shr_q <= shr_d;  wps_q <= wps_d;
      first_q <= first_d;  beat_q <= beat_d;  nload_q <= nload_d;  base_q <= base_d;  be_q <= be_d;
      rdy_q <= rdy_d;  done_q <= done_d;  fv_q <= fv_d;  ex_q <= ex_d;  rdv_q <= rdv_d;
      perr1_q <= perr1_d;  perr_n_q <= perr_n_d;  fs_q <= fs_d;  rw_q <= rw_d;
      rd_q <= rd_d;  dout_q <= dout_d;  ads_n_q <= ads_n_d;  cache_n_q <= cache_n_d;  oe_q <= oe_d;
    end
  end

  // Kept for replay after backoff
  always_ff @(posedge clk) begin
    if (pop) begin
      buf_q[nload_q[1:0]] <= fifo_d;
    end
  end

  assign req_ready              = rdy_q;
  assign rdata_valid            = rdv_q;
  assign rdata                  = rd_q;
  assign rdata_word             = rw_q;
  assign cycle_done             = done_q;
  assign fill_valid             = fv_q;
  assign fill_state             = fs_q;
  assign to_exclusive           = ex_q;
  assign bus.bus_start_n        = ads_n_q;
  assign bus.addr               = {base_q, first_q};
  assign bus.byte_en_n          = ~be_q;
  assign bus.cyc_write          = wr_q;
  assign bus.cyc_io             = io_q;
  assign bus.cacheable_cycle_n  = cache_n_q;
  assign bus.page_write_through = pwt_q;
  assign bus.cpu_data           = dout_q;
  assign bus.cpu_parity         = cnbc_lane_par(dout_q);
  assign bus.cpu_data_oe        = oe_q;
  assign bus.parity_error_n     = perr_n_q;
endmodule
`default_nettype wire

// file: rtl/cnbc_pkg.sv
// Purpose: Shared constants and helpers for the non-pipelined host bus ends
// Assumes: 64-bit data bus, 32-byte lines, four beats per line
// Notes:   Burst word order and lane parity are used by both ends
package cnbc_pkg;
  localparam int         ADDR_W       = 32;
  localparam int         DATA_W       = 64;
  localparam int         LANES        = 8;
  localparam int         WORD_LSB     = 3;
  localparam int         LINE_LSB     = 5;
  localparam int         BEATS        = 4;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         HOST_WORDS   = 64;
  localparam logic [1:0] LAST_BEAT    = 2'h3;
  localparam logic [1:0] ALIGNED_WORD = 2'h0;
  localparam logic [1:0] FILL_SHARED  = 2'h1;
  localparam logic [1:0] FILL_EXCL    = 2'h2;
  localparam logic [1:0] FILL_NONE    = 2'h0;
  localparam logic [3:0] WAIT_NONE    = 4'h0;
  localparam logic [3:0] WAIT_LAST    = 4'h1;

  // Word of a beat; both orders reduce to first plus beat
  function automatic logic [1:0] cnbc_burst_word(input logic [1:0] first, input logic [1:0] beat);
    cnbc_burst_word = first + beat;
  endfunction

  // One even-parity bit per byte lane
  function automatic logic [LANES-1:0] cnbc_lane_par(input logic [DATA_W-1:0] d);
    logic [LANES-1:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    cnbc_lane_par = p;
  endfunction
endpackage

// file: rtl/cnbc_bus_if.sv
// Purpose: Host bus wires between processor end and system end
// Assumes: Data bus resolved from the processor output enable alone; system data otherwise
// Notes:   No clocking; both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface cnbc_bus_if;
  import cnbc_pkg::*;
  logic                      bus_start_n;
  logic [ADDR_W-1:WORD_LSB]  addr;
  logic [LANES-1:0]          byte_en_n;
  logic                      cyc_write;
  logic                      cyc_io;
  logic                      cacheable_cycle_n;
  logic                      page_write_through;
  logic [DATA_W-1:0]         cpu_data;
  logic [LANES-1:0]          cpu_parity;
  logic                      cpu_data_oe;
  logic [DATA_W-1:0]         sys_data;
  logic [LANES-1:0]          sys_parity;
  logic                      sys_data_oe;
  logic                      transfer_ready_n;
  logic                      cache_enable_n;
  logic                      write_policy_sel;
  logic                      next_address_n;
  logic                      backoff_n;
  logic                      parity_error_n;
  logic [DATA_W-1:0]         data;
  logic [LANES-1:0]          parity;

  assign data   = cpu_data_oe ? cpu_data : sys_data;
  assign parity = cpu_data_oe ? cpu_parity : sys_parity;

  modport cpu (
    output bus_start_n, addr, byte_en_n, cyc_write, cyc_io, cacheable_cycle_n,
    output page_write_through, cpu_data, cpu_parity, cpu_data_oe, parity_error_n,
    input  data, parity, transfer_ready_n, cache_enable_n, write_policy_sel,
    input  next_address_n, backoff_n
  );
  modport sys (
    input  bus_start_n, addr, byte_en_n, cyc_write, cyc_io, cacheable_cycle_n,
    input  page_write_through, data, parity, parity_error_n,
    output sys_data, sys_parity, sys_data_oe, transfer_ready_n, cache_enable_n,
    output write_policy_sel, next_address_n, backoff_n
  );
endinterface
`default_nettype wire

// file: rtl/cnbc_sys_end.sv
// Purpose: System end of the host bus: ready, cache enable, policy, memory
// Assumes: Processor keeps one cycle outstanding
// Notes:   Predicts burst words itself from the first address
`timescale 1ns/100ps
`default_nettype none
module cnbc_sys_end (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Response policy
  input  wire logic [3:0] wait_states,
  input  wire logic       cache_ok,
  input  wire logic       write_back_ok,
  input  wire logic       linear_burst,
  input  wire logic       backoff_req,
  input  wire logic       corrupt_parity,
  // Status
  output logic            beat_seen,
  output logic            parity_error_seen,
  // Host bus
  cnbc_bus_if.sys         bus
);
  import cnbc_pkg::*;

  logic [DATA_W-1:0] mem [HOST_WORDS];
  logic              act_q, act_d, wr_q, wr_d, burst_q, burst_d, transfer_ready_n_q, transfer_ready_n_d, oe_q, oe_d;
  logic [1:0]        first_q, first_d, beat_q, beat_d;
  logic [3:0]        wait_q, wait_d;
  logic [3:0]        line_q, line_d;
  logic              ken_n_q, wps_q, backoff_n_n_q, seen_q, perr_q, bad_q;
  logic [DATA_W-1:0] dat_q, dat_d;
  logic [5:0]        idx;
  logic              beat_done;

  assign beat_done = act_q && transfer_ready_n_q && backoff_n_n_q;
  assign idx       = {line_q, cnbc_burst_word(first_q, beat_q)};

  always_comb begin
    act_d = act_q;  wr_d = wr_q;  burst_d = burst_q;  first_d = first_q;
    beat_d = beat_q;  wait_d = wait_q;  line_d = line_q;  transfer_ready_n_d = 1'b0;
    oe_d = oe_q;  dat_d = dat_q;
    if (!backoff_n_n_q) begin
      act_d = 1'b0;
      oe_d  = 1'b0;
    end else if (!act_q && !bus.bus_start_n) begin
      act_d   = 1'b1;
      wr_d    = bus.cyc_write;
      first_d = bus.addr[LINE_LSB-1:WORD_LSB];
      line_d  = bus.addr[LINE_LSB+3:LINE_LSB];
      beat_d  = 2'h0;
      burst_d = 1'b0;
      wait_d  = wait_states;
      transfer_ready_n_d  = (wait_states == WAIT_NONE);
      oe_d    = !bus.cyc_write;
      dat_d   = mem[{bus.addr[LINE_LSB+3:LINE_LSB], bus.addr[LINE_LSB-1:WORD_LSB]}];
    end else if (beat_done) begin
      if (beat_q == 2'h0) begin
        burst_d = !bus.cacheable_cycle_n && (wr_q || !ken_n_q);
      end
      if (!burst_d || beat_q == LAST_BEAT) begin
        act_d = 1'b0;
        oe_d  = 1'b0;
      end else begin
        beat_d = beat_q + 2'h1;
        wait_d = wait_states;
        transfer_ready_n_d = (wait_states == WAIT_NONE);
        dat_d  = mem[{line_q, cnbc_burst_word(first_q, beat_d)}];
      end
    end else if (act_q) begin
      wait_d = (wait_q == WAIT_NONE) ? WAIT_NONE : wait_q - 4'h1;
      transfer_ready_n_d = (wait_q == WAIT_LAST);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_q <= 1'b0;  wr_q <= 1'b0;  burst_q <= 1'b0;  first_q <= 2'h0;  beat_q <= 2'h0;
      wait_q <= WAIT_NONE;  line_q <= 4'h0;  transfer_ready_n_q <= 1'b0;  oe_q <= 1'b0;  dat_q <= '0;
      ken_n_q <= 1'b1;  wps_q <= 1'b0;  backoff_n_n_q <= 1'b1;  seen_q <= 1'b0;  perr_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      act_q <= act_d;  wr_q <= wr_d;  burst_q <= burst_d;  first_q <= first_d;  beat_q <= beat_d;
      wait_q <= wait_d;  line_q <= line_d;  transfer_ready_n_q <= transfer_ready_n_d;  oe_q <= oe_d;  dat_q <= dat_d;
      ken_n_q <= !cache_ok;
      wps_q <= write_back_ok;
      backoff_n_n_q <= !backoff_req;
      seen_q <= beat_done;
      perr_q <= !bus.parity_error_n;
      bad_q <= corrupt_parity;
    end
  end

  // Write beats land in the predicted word
  always_ff @(posedge clk) begin
    if (beat_done && wr_q) begin
      mem[idx] <= bus.data;
    end
  end

  // Test hook spoils lane 0 parity
  assign bus.sys_data         = dat_q;
  assign bus.sys_parity       = cnbc_lane_par(dat_q) ^ {{(LANES-1){1'b0}}, bad_q};
  assign bus.sys_data_oe      = oe_q;
  assign bus.transfer_ready_n = !transfer_ready_n_q;
  assign bus.cache_enable_n   = ken_n_q;
  assign bus.write_policy_sel = wps_q;
  assign bus.next_address_n   = 1'b1;
  assign bus.backoff_n        = backoff_n_n_q;
  assign beat_seen            = seen_q;
  assign parity_error_seen    = perr_q;
endmodule
`default_nettype wire

// file: verif/cnbc_bus_sva.sv
// Purpose: Wire-level checks of the host bus
// Assumes: One clock, async high reset
// Notes:   Watches the interface wires only
`timescale 1ns/100ps
`default_nettype none
module cnbc_bus_sva (
  // Clock and reset
  input wire logic                                         clk,
  input wire logic                                         reset,
  // Bus wires
  input wire logic                                         bus_start_n,
  input wire logic [cnbc_pkg::ADDR_W-1:cnbc_pkg::WORD_LSB] addr,
  input wire logic [cnbc_pkg::LANES-1:0]                   byte_en_n,
  input wire logic                                         cyc_write,
  input wire logic                                         cacheable_cycle_n,
  input wire logic                                         cpu_data_oe,
  input wire logic                                         transfer_ready_n,
  input wire logic                                         next_address_n,
  input wire logic                                         backoff_n,
  input wire logic                                         parity_error_n,
  input wire logic [cnbc_pkg::DATA_W-1:0]                  data,
  input wire logic [cnbc_pkg::LANES-1:0]                   parity
);
  import cnbc_pkg::*;
  logic [2:0]       beat_q;
  logic [2:0]       beat_d;
  logic [LANES-1:0] bad;
  // Beats recount from each start
  always_comb begin
    beat_d = beat_q;
    if (!bus_start_n)
      beat_d = 3'h0;
    else if (!transfer_ready_n && backoff_n)
      beat_d = beat_q + 3'h1;
    for (int i = 0; i < LANES; i++)
      bad[i] = (parity[i] ^ (^data[i*8 +: 8])) & ~byte_en_n[i];
  end
  always_ff @(posedge clk or posedge reset)
    if (reset)
      beat_q <= 3'h0;
    else
      beat_q <= beat_d;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr_last;
    !transfer_ready_n && backoff_n && cyc_write && !cacheable_cycle_n && beat_q == 3'h3;
  endsequence
  sequence s_rd_bad;
    !transfer_ready_n && backoff_n && !cyc_write && (|bad);
  endsequence
  sequence s_wr_wait;
    (!bus_start_n && cyc_write && backoff_n) ##1 (transfer_ready_n && backoff_n);
  endsequence
  AST_NEXT_ADDR: assert property (next_address_n)
    else $error("next address low");
  AST_ONE_CYCLE: assert property (!bus_start_n |=> bus_start_n)
    else $error("start inside a cycle");
  AST_T1_WAIT: assert property (!bus_start_n |-> transfer_ready_n)
    else $error("ready in first clock");
  AST_RD_PARITY: assert property (s_rd_bad |-> ##2 !parity_error_n)
    else $error("parity error not flagged");
  AST_WR_ALIGN: assert property (!bus_start_n && cyc_write && !cacheable_cycle_n |-> addr[4:3] == ALIGNED_WORD)
    else $error("burst write not aligned");
  AST_WR_DRIVE: assert property (!bus_start_n && cyc_write && backoff_n |=> cpu_data_oe)
    else $error("write data not driven");
  AST_WR_HOLD: assert property (s_wr_wait |=> cpu_data_oe && $stable(data))
    else $error("write data moved in wait");
  AST_WR_GAP: assert property (s_wr_last |=> bus_start_n)
    else $error("no idle after burst write");
  AST_BEATS: assert property (!transfer_ready_n && backoff_n |-> beat_q < 3'h4)
    else $error("too many ready strobes");
  AST_CACHE_HOLD: assert property (!bus_start_n && !cacheable_cycle_n && backoff_n |=> !cacheable_cycle_n)
    else $error("cacheable dropped");
  AST_BACKOFF: assert property (!backoff_n |=> bus_start_n && !cpu_data_oe)
    else $error("bus busy after backoff");
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Bench for both host bus ends joined by the interface
// Assumes: Words are read only after being written
// Notes:   All lanes on and io cycles off, to keep the model small
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import cnbc_pkg::*;
  logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_line = 1'b0, req_io = 1'b0;
  logic req_page_wt = 1'b0, req_shared_hit = 1'b0, wdata_valid = 1'b0, linear_burst = 1'b0;
  logic write_through_cfg = 1'b0, cache_ok = 1'b1, write_back_ok = 1'b0, backoff_req = 1'b0, corrupt_parity = 1'b0;
  logic [3:0] wait_states = 4'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [LANES-1:0] req_byte_en = 8'hff;
  logic [DATA_W-1:0] wdata = '0, rdata, mem[int], wq[$];
  logic req_ready, wdata_ready, rdata_valid, cycle_done, fill_valid, to_exclusive, beat_seen, parity_error_seen;
  logic [1:0] rdata_word, fill_state;
  logic [DATA_W+1:0] got[$], expq[$];
  int miscompares = 0, check_count = 0, perr_n = 0, texc_n = 0, n, t;
  cnbc_bus_if cnbc_bus_if_i ();
  cnbc_cpu_end cnbc_cpu_end_i (.clk, .reset, .req_valid, .req_ready, .req_write, .req_line, .req_io, .req_page_wt,
    .req_shared_hit, .req_addr, .req_byte_en, .wdata_valid, .wdata_ready, .wdata, .rdata_valid, .rdata, .rdata_word,
    .cycle_done, .fill_valid, .fill_state, .to_exclusive, .linear_burst, .write_through_cfg, .bus(cnbc_bus_if_i.cpu));
  cnbc_sys_end cnbc_sys_end_i (.clk, .reset, .wait_states, .cache_ok, .write_back_ok, .linear_burst, .backoff_req,
    .corrupt_parity, .beat_seen, .parity_error_seen, .bus(cnbc_bus_if_i.sys));
  cnbc_bus_sva cnbc_bus_sva_i (.clk, .reset, .bus_start_n(cnbc_bus_if_i.bus_start_n), .addr(cnbc_bus_if_i.addr),
    .byte_en_n(cnbc_bus_if_i.byte_en_n), .cyc_write(cnbc_bus_if_i.cyc_write), .data(cnbc_bus_if_i.data),
    .cacheable_cycle_n(cnbc_bus_if_i.cacheable_cycle_n), .cpu_data_oe(cnbc_bus_if_i.cpu_data_oe),
    .transfer_ready_n(cnbc_bus_if_i.transfer_ready_n), .next_address_n(cnbc_bus_if_i.next_address_n),
    .backoff_n(cnbc_bus_if_i.backoff_n), .parity_error_n(cnbc_bus_if_i.parity_error_n), .parity(cnbc_bus_if_i.parity));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (rdata_valid === 1'b1)
      got.push_back({rdata_word, rdata});
    if (parity_error_seen === 1'b1)
      perr_n++;
    if (to_exclusive === 1'b1)
      texc_n++;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded idle wait
  task automatic wait_idle();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    @(posedge clk);
    if (n >= 400) begin
      miscompares++;
      $display("mismatch t=%0t stuck", $time);
      summarize();
    end
  endtask
  // Request stays up for chaining
  task automatic op(input logic w, l, sh, input logic [ADDR_W-1:0] a);
    req_write <= w;
    req_line <= l;
    req_shared_hit <= sh;
    req_addr <= a;
    req_valid <= 1'b1;
    wait_idle();
  endtask
  task automatic finish();
    req_valid <= 1'b0;
    wait_idle();
    repeat (3) @(posedge clk);
  endtask
  task automatic fill_fifo(input int lim);
    logic [DATA_W-1:0] v;
    logic r;
    n = 0;
    wdata_valid <= 1'b1;
    do begin
      v = {$urandom, $urandom};
      wdata <= v;
      @(negedge clk);
      r = wdata_ready;
      @(posedge clk);
      if (r === 1'b1) begin
        wq.push_back(v);
        n++;
      end
    end while (r === 1'b1 && n < lim);
    wdata_valid <= 1'b0;
  endtask
  task automatic wr(input logic l, sh, input logic [ADDR_W-1:0] a);
    op(1'b1, l, sh, a);
    for (int k = 0; k < (l ? BEATS : 1); k++)
      mem[a / 8 + k] = wq.pop_front();
  endtask
  task automatic rd(input logic l, input logic [ADDR_W-1:0] a, input int np);
    int w;
    int f;
    int p0;
    w = a[4:3];
    f = (l && cache_ok) ? (linear_burst ? w : w & 2) : w;
    p0 = perr_n;
    got.delete();
    expq.delete();
    if (l && cache_ok && !linear_burst && w[0])
      expq.push_back({w[1:0], mem[a / 8]});
    for (int k = 0; k < ((l && cache_ok) ? BEATS : 1); k++)
      expq.push_back({2'(f + k), mem[a / 32 * 4 + (f + k) % 4]});
    req_page_wt <= 1'($urandom);
    op(1'b0, l, 1'b0, a);
    finish();
    `CHK(got.size(), expq.size())
    foreach (expq[i]) `CHK(got[i], expq[i])
    `CHK(perr_n - p0, np)
    if (l && cache_ok) `CHK(fill_state, (write_back_ok && !req_page_wt && !write_through_cfg) ? FILL_EXCL : FILL_SHARED)
  endtask
  initial begin
    n = $urandom(69320);
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wait_states <= 4'h2;
    fill_fifo(40);
    `CHK(n, FIFO_DEPTH)
    for (int i = 0; i < 4; i++)
      wr(1'b1, 1'b0, i * 32);
    finish();
    $display("test line writes done");
    for (int p = 0; p < 2; p++) begin
      write_back_ok <= 1'(p);
      fill_fifo(1);
      t = texc_n;
      wr(1'b0, 1'b1, 32'h0000_0080 + p * 8);
      finish();
      `CHK(texc_n - t, p)
    end
    $display("test shared writes done");
    for (int i = 0; i < 16; i++) begin
      linear_burst <= i[3];
      cache_ok <= i[2];
      write_back_ok <= 1'($urandom);
      write_through_cfg <= 1'($urandom);
      wait_states <= 4'($urandom_range(3, 0));
      @(posedge clk);
      rd(1'b1, i[1:0] * 8 + $urandom_range(3, 0) * 32, 0);
    end
    rd(1'b0, 32'h0000_0088, 0);
    $display("test reads done");
    corrupt_parity <= 1'b1;
    linear_burst <= 1'b0;
    cache_ok <= 1'b1;
    @(posedge clk);
    rd(1'b0, 32'h0000_0010, 1);
    rd(1'b1, 32'h0000_0008, 5);
    corrupt_parity <= 1'b0;
    $display("test parity done");
    fill_fifo(4);
    wait_states <= 4'h3;
    wr(1'b1, 1'b0, 32'h0000_00a0);
    req_valid <= 1'b0;
    repeat (6) @(posedge clk);
    backoff_req <= 1'b1;
    @(posedge clk);
    backoff_req <= 1'b0;
    finish();
    rd(1'b1, 32'h0000_00a8, 0);
    $display("test backoff done");
    summarize();
  end
endmodule
`default_nettype wire
